// [bench/ssar_host.sv]
// Host controller model for the two-wire management link
`timescale 1ns/1ps
`default_nettype none

module ssar_host (
  // Clock
  input  wire logic clock,
  // Link, open drain: 1 releases the data line
  input  wire logic sdaIn,
  output logic      scl,
  output logic      sdaDrv
);
  logic [7:0] rxBuf [0:15];
  logic [7:0] shReg;
  int         ackMiss = 0;

  initial
  begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  // Data moves only while the clock is low; sampled mid-high
  task automatic xbit(input logic b);
    sdaDrv = b;
    tick(4);
    scl = 1'b1;
    tick(2);
    shReg = {shReg[6:0], sdaIn};
    tick(2);
    scl = 1'b0;
    tick(1);
  endtask : xbit

  task automatic xbyte(input logic [7:0] tx, input logic nack, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) xbit(tx[i]);
    rx = shReg;
    xbit((tx != 8'hff) | nack);
    if (tx != 8'hff && shReg[0]) ackMiss++;
  endtask : xbyte

  task automatic readCmd(input logic [7:0] cmd, input int n);
    logic [7:0] d;
    sdaDrv = 1'b0;
    tick(4);
    scl = 1'b0;
    tick(1);
    xbyte({ssar_pkg::DEV_ADDR, 1'b0}, 1'b0, d);
    xbyte(cmd, 1'b0, d);
    sdaDrv = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sdaDrv = 1'b0;
    tick(4);
    scl = 1'b0;
    tick(1);
    xbyte({ssar_pkg::DEV_ADDR, 1'b1}, 1'b0, d);
    // no-ack on the last byte, then stop
    for (int i = 0; i < n; i++) xbyte(8'hff, i == n - 1, rxBuf[i]);
    sdaDrv = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sdaDrv = 1'b1;
    tick(4);
  endtask : readCmd
endmodule : ssar_host

`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the status and alarm readback block
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        scl, sdaDrv, sdaOut, sdaOe, unitShutdown;
  logic        cfgWrite, cfgOcHiccup, cfgOtHiccup, clearFaults, pecFailEvent;
  logic        valueRangeError, remoteOnHigh, internalFault, shutdownIn, serviceLedOn;
  logic        externalFault, indicatorCheckActive, outputOn, oringTestDone;
  logic        oringTestPass, oringSelfFail, oringDestructive, interlockOpen, fuseFail;
  logic [2:0]  commFaults;
  logic [7:1]  alarm2Flags;
  logic [7:0]  alarm1Flags;
  logic [15:0] shareCurrentMa, voltage, current;
  logic [15:0] tempConv, tempConvLimit, tempInput, tempInputLimit;
  int          mismatches = 0;
  int          cmp_count = 0;
  // Released line reads high through the pull-up; a driven line shows the device's level
  wire         sdaWire = sdaDrv & (sdaOe ? sdaOut : 1'b1);

  always #5 clock = ~clock;

  ssar_host host (.clock, .sdaIn(sdaWire), .scl, .sdaDrv);

  ssar_readback dut (
    .clock, .rst_n, .scl, .sdaIn(sdaWire), .sdaOut, .sdaOe,
    .cfgWrite, .cfgOcHiccup, .cfgOtHiccup, .clearFaults, .pecFailEvent,
    .valueRangeError, .remoteOnHigh, .internalFault, .shutdownIn, .serviceLedOn,
    .externalFault, .indicatorCheckActive, .outputOn, .oringTestDone, .oringTestPass,
    .oringSelfFail, .oringDestructive, .interlockOpen, .fuseFail, .commFaults,
    .alarm2Flags, .alarm1Flags, .shareCurrentMa, .voltage, .current, .tempConv,
    .tempConvLimit, .tempInput, .tempInputLimit, .unitShutdown
  );

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [7:0] crcByte(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? ((r << 1) ^ ssar_pkg::CRC_POLY) : (r << 1);
    return r;
  endfunction : crcByte

  // Expected bytes are packed first byte highest
  task automatic readCheck(input logic [7:0] cmd, input int n, input logic [127:0] v);
    logic [7:0] c;
    c = crcByte(crcByte(ssar_pkg::CRC_INIT, {ssar_pkg::DEV_ADDR, 1'b0}), cmd);
    c = crcByte(c, {ssar_pkg::DEV_ADDR, 1'b1});
    host.readCmd(cmd, n + 1);
    for (int i = 0; i < n; i++)
    begin
      check("read byte", host.rxBuf[i], v[8 * (n - 1 - i) +: 8]);
      c = crcByte(c, v[8 * (n - 1 - i) +: 8]);
    end
    check("check byte", host.rxBuf[n], c);
    check("acks", 8'(host.ackMiss), 8'h00);
  endtask : readCheck

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_unit;
    {valueRangeError, remoteOnHigh, serviceLedOn, outputOn} = 4'hf;
    readCheck(ssar_pkg::CMD_UNIT, 2, 16'h4389);
    // Sticky check error, unknown command and every live status input raised
    {internalFault, shutdownIn, externalFault, indicatorCheckActive, pecFailEvent} = 5'h1f;
    host.tick(1);
    pecFailEvent = 1'b0;
    host.tick(2);
    check("shutdown", {7'h00, unitShutdown}, 8'h01);
    host.readCmd(8'h00, 1);
    check("fill byte", host.rxBuf[0], ssar_pkg::FILL_BYTE);
    readCheck(ssar_pkg::CMD_UNIT, 2, 16'he3bf);
    {internalFault, shutdownIn, externalFault, indicatorCheckActive, clearFaults} = 5'h01;
    host.tick(1);
    clearFaults = 1'b0;
    host.tick(2);
  endtask : sc_unit

  task automatic sc_alarm;
    {interlockOpen, fuseFail, commFaults} = 5'h15;
    alarm2Flags = 7'h55;
    alarm1Flags = 8'h3c;
    // Share limit boundary: equal stays clear, one above raises the fault
    for (int s = 0; s < 2; s++)
    begin
      shareCurrentMa = 16'h1b58 + 16'(s);
      readCheck(ssar_pkg::CMD_ALARM, 4, {8'h03, 8'ha8, 7'h55, s[0], 8'h3c});
    end
  endtask : sc_alarm

  task automatic sc_summary;
    {voltage, current} = 32'h1234_5678;
    {tempConv, tempConvLimit, tempInput, tempInputLimit} = 64'h0040_0064_0050_0060;
    readCheck(ssar_pkg::CMD_SUMMARY, 12, 96'h0b_43_89_a8_ab_3c_34_12_78_56_50_00);
  endtask : sc_summary

  task automatic sc_oring;
    // spare capacity taken as confirmed before the test
    {oringDestructive, oringTestPass, oringTestDone} = 3'h5;
    host.tick(1);
    oringTestDone = 1'b0;
    host.tick(2);
    check("shutdown", {7'h00, unitShutdown}, 8'h01);
    readCheck(ssar_pkg::CMD_UNIT, 2, 16'h4b99);
    readCheck(ssar_pkg::CMD_ALARM, 4, 32'h03a9ab3c);
    {clearFaults, cfgWrite, cfgOcHiccup, cfgOtHiccup, oringDestructive} = 5'h1c;
    host.tick(1);
    // Self-test fault and clear in one cycle: the fault must survive
    {clearFaults, cfgWrite, oringSelfFail} = 3'h5;
    host.tick(1);
    {clearFaults, oringSelfFail} = 2'b00;
    host.tick(2);
    check("shutdown", {7'h00, unitShutdown}, 8'h00);
    readCheck(ssar_pkg::CMD_UNIT, 2, 16'h4309);
    readCheck(ssar_pkg::CMD_ALARM, 4, 32'h03a9ab3c);
  endtask : sc_oring

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    {cfgWrite, cfgOcHiccup, cfgOtHiccup, clearFaults, pecFailEvent, valueRangeError,
     remoteOnHigh, internalFault, shutdownIn, serviceLedOn, externalFault,
     indicatorCheckActive, outputOn, oringTestDone, oringTestPass, oringSelfFail,
     oringDestructive, interlockOpen, fuseFail, commFaults, alarm2Flags, alarm1Flags,
     shareCurrentMa, voltage, current, tempConv, tempConvLimit, tempInput,
     tempInputLimit} = '0;
    repeat (4) @(posedge clock);
    #1;
    rst_n = 1'b1;
    host.tick(2);
    sc_unit();
    sc_alarm();
    sc_summary();
    sc_oring();
    wrap_up();
  end
endmodule : tb

`default_nettype wire

// [hdl/ssar_pkg.sv]
// Constants shared by the supply status and alarm readback block
package ssar_pkg;

  // ----------------------------------------------------------------
  // Link addressing and commands
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR     = 7'h58;
  localparam logic [7:0] CMD_SUMMARY  = 8'hd0;
  localparam logic [7:0] CMD_UNIT     = 8'hd1;
  localparam logic [7:0] CMD_ALARM    = 8'hd2;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [7:0] SUMMARY_COUNT = 8'h0b;
  localparam logic [7:0] ALARM_COUNT   = 8'h03;
  localparam logic [3:0] SUMMARY_LAST  = 4'hc;
  localparam logic [3:0] UNIT_LAST     = 4'h2;
  localparam logic [3:0] ALARM_LAST    = 4'h4;
  localparam logic [3:0] IDX_MAX       = 4'hf;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [2:0] TX_LAST_BIT   = 3'h7;
  localparam logic [2:0] TX_NEXT_TOP   = 3'h6;
  localparam logic [7:0] FILL_BYTE     = 8'hff;
  localparam logic [7:0] CRC_POLY      = 8'h07;
  localparam logic [7:0] CRC_INIT      = 8'h00;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic       RESET_OC_HICCUP = 1'b1;
  localparam logic       RESET_OT_HICCUP = 1'b1;
  localparam int         SHARE_LIMIT_A   = 7;
  localparam logic [15:0] SHARE_LIMIT_MA = 16'(SHARE_LIMIT_A * 1000);

  // ----------------------------------------------------------------
  // Link engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b010,
    ST_TX   = 3'b011,
    ST_HACK = 3'b100,
    ST_WAIT = 3'b101
  } ssar_state_t;

endpackage : ssar_pkg

// [hdl/ssar_readback.sv]
// Status and alarm readback engine on the two-wire management link
// Operation
// R1 - Reads longer than two bytes use block read after repeated start.
// R2 - Block read starts with byte count excluding the check byte.
// R3 - Measured values go out low byte first, then high byte.
// R4 - Host not-acknowledging the check byte ends the transfer.
// R5 - Summary returns status, alarms, voltage, current, temperature in fixed order.
// R6 - Summary temperature is the reading nearest its shutdown limit.
// R7 - Unit status returns second then first status byte as word read.
// R8 - Alarm command returns alarm bytes three, two, one.
// R9 - Second status byte holds check error, invalid, or-ing fail, range, remote.
// R10 - Second status bit 6 selects overcurrent hiccup, default one.
// R11 - First status byte layout, over-temperature response defaults to hiccup.
// R12 - Alarm three layout, unused bits zero, all default zero.
// R13 - Alarm two layout ending with share sourcing fault.
// R14 - Share sourcing above seven amperes raises the sourcing fault.
// R15 - Or-ing fault from host test or internal self test.
// R16 - Destructive or-ing fault shuts unit down, non-destructive only flags.
// R17 - Host confirms spare capacity before starting an or-ing test.
// R18 - Unused status and alarm bits always read zero.
// R19 - Every read of a known command ends with a packet error check byte; a read after an unknown command returns only fill bytes.
`timescale 1ns/1ps
`default_nettype none

module ssar_readback (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Two-wire link
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // Configuration from supply control
  input  wire logic        cfgWrite,
  input  wire logic        cfgOcHiccup,
  input  wire logic        cfgOtHiccup,
  input  wire logic        clearFaults,
  // Status inputs
  input  wire logic        pecFailEvent,
  input  wire logic        valueRangeError,
  input  wire logic        remoteOnHigh,
  input  wire logic        internalFault,
  input  wire logic        shutdownIn,
  input  wire logic        serviceLedOn,
  input  wire logic        externalFault,
  input  wire logic        indicatorCheckActive,
  input  wire logic        outputOn,
  // Or-ing test events
  input  wire logic        oringTestDone,
  input  wire logic        oringTestPass,
  input  wire logic        oringSelfFail,
  input  wire logic        oringDestructive,
  // Alarm inputs
  input  wire logic        interlockOpen,
  input  wire logic        fuseFail,
  input  wire logic [2:0]  commFaults,
  input  wire logic [7:1]  alarm2Flags,
  input  wire logic [7:0]  alarm1Flags,
  input  wire logic [15:0] shareCurrentMa,
  // Measurements
  input  wire logic [15:0] voltage,
  input  wire logic [15:0] current,
  input  wire logic [15:0] tempConv,
  input  wire logic [15:0] tempConvLimit,
  input  wire logic [15:0] tempInput,
  input  wire logic [15:0] tempInputLimit,
  // Unit control
  output logic             unitShutdown
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] crcNext(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ ssar_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crcNext

  function automatic logic [3:0] cmdLast(input logic [7:0] cmd);
    unique case (cmd)
      ssar_pkg::CMD_SUMMARY: return ssar_pkg::SUMMARY_LAST;
      ssar_pkg::CMD_UNIT:    return ssar_pkg::UNIT_LAST;
      ssar_pkg::CMD_ALARM:   return ssar_pkg::ALARM_LAST;
      default:               return 4'h0;
    endcase
  endfunction : cmdLast

  // ----------------------------------------------------------------
  // Status and alarm state
  // ----------------------------------------------------------------
  logic        ocHiccup_reg,   ocHiccup_next;
  logic        otHiccup_reg,   otHiccup_next;
  logic        pecErr_reg,     pecErr_next;
  logic        invalid_reg,    invalid_next;
  logic        oringFail_reg,  oringFail_next;
  logic        oringOk_reg,    oringOk_next;
  logic        oringFault_reg, oringFault_next;
  logic        shutLatch_reg,  shutLatch_next;
  logic        shareFault_reg, shareFault_next;
  logic        shutdown_reg,   shutdown_next;
  logic [15:0] tempSel_reg,    tempSel_next;
  logic        invalidSet;
  logic        oringEvt;
  logic [15:0] marginConv;
  logic [15:0] marginInput;
  logic [7:0]  status2;
  logic [7:0]  status1;
  logic [7:0]  alarm3;
  logic [7:0]  alarm2;

  always_comb
  begin
    oringEvt        = (oringTestDone & ~oringTestPass) | oringSelfFail;
    ocHiccup_next   = cfgWrite ? cfgOcHiccup : ocHiccup_reg;
    otHiccup_next   = cfgWrite ? cfgOtHiccup : otHiccup_reg;
    // Hardware set wins over a clear arriving in the same cycle
    pecErr_next     = pecFailEvent | (pecErr_reg & ~clearFaults);
    invalid_next    = invalidSet | (invalid_reg & ~clearFaults);
    oringFail_next  = (oringTestDone & ~oringTestPass) | (oringFail_reg & ~clearFaults);
    oringOk_next    = oringTestDone ? oringTestPass : oringOk_reg;
    // R15 host test or self test
    oringFault_next = oringEvt | (oringFault_reg & ~clearFaults);
    // R16 only destructive faults shut down
    shutLatch_next  = (oringEvt & oringDestructive) | (shutLatch_reg & ~clearFaults);
    shutdown_next   = shutdownIn | shutLatch_next;
    // R14 sourcing limit
    shareFault_next = shareCurrentMa > ssar_pkg::SHARE_LIMIT_MA;
    // R6 reading with least headroom to its shutdown limit
    marginConv      = (tempConv >= tempConvLimit) ? 16'h0000 : tempConvLimit - tempConv;
    marginInput     = (tempInput >= tempInputLimit) ? 16'h0000 : tempInputLimit - tempInput;
    tempSel_next    = (marginInput < marginConv) ? tempInput : tempConv;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ocHiccup_reg   <= ssar_pkg::RESET_OC_HICCUP;
      otHiccup_reg   <= ssar_pkg::RESET_OT_HICCUP;
      pecErr_reg     <= 1'b0;
      invalid_reg    <= 1'b0;
      oringFail_reg  <= 1'b0;
      oringOk_reg    <= 1'b0;
      oringFault_reg <= 1'b0;
      shutLatch_reg  <= 1'b0;
      shareFault_reg <= 1'b0;
      shutdown_reg   <= 1'b0;
      tempSel_reg    <= 16'h0000;
    end
    else
    begin
      ocHiccup_reg   <= ocHiccup_next;
      otHiccup_reg   <= otHiccup_next;
      pecErr_reg     <= pecErr_next;
      invalid_reg    <= invalid_next;
      oringFail_reg  <= oringFail_next;
      oringOk_reg    <= oringOk_next;
      oringFault_reg <= oringFault_next;
      shutLatch_reg  <= shutLatch_next;
      shareFault_reg <= shareFault_next;
      shutdown_reg   <= shutdown_next;
      tempSel_reg    <= tempSel_next;
    end
  end

  assign unitShutdown = shutdown_reg;
  // R9 R10 R18 second status byte
  assign status2 = {pecErr_reg, ocHiccup_reg, invalid_reg, 1'b0,
                    oringFail_reg, 1'b0, valueRangeError, remoteOnHigh};
  // R11 first status byte
  assign status1 = {otHiccup_reg, oringOk_reg, internalFault, shutdown_reg,
                    serviceLedOn, externalFault, indicatorCheckActive, outputOn};
  // R12 R18 alarm three
  assign alarm3  = {interlockOpen, fuseFail, commFaults, 2'b00, oringFault_reg};
  // R13 alarm two
  assign alarm2  = {alarm2Flags, shareFault_reg};

  // ----------------------------------------------------------------
  // Link engine
  // ----------------------------------------------------------------
  ssar_pkg::ssar_state_t state_reg, state_next;
  logic        sclPrev_reg,   sclPrev_next;
  logic        sdaPrev_reg,   sdaPrev_next;
  logic [3:0]  bitCnt_reg,    bitCnt_next;
  logic [7:0]  shift_reg,     shift_next;
  logic        addrPhase_reg, addrPhase_next;
  logic        rdMode_reg,    rdMode_next;
  logic [7:0]  cmd_reg,       cmd_next;
  logic [3:0]  idx_reg,       idx_next;
  logic [7:0]  crc_reg,       crc_next;
  logic [7:0]  txByte_reg,    txByte_next;
  logic        sdaOe_reg,     sdaOe_next;
  logic        sdaOut_reg;
  logic        sclRise, sclFall, startCond, stopCond;
  logic [3:0]  lastIdx, loadIdx;
  logic [7:0]  loadByte;
  logic [7:0]  sumBytes [0:11];
  logic [7:0]  alarmBytes [0:3];

  assign sclRise   = scl & ~sclPrev_reg;
  assign sclFall   = ~scl & sclPrev_reg;
  assign startCond = scl & sclPrev_reg & sdaPrev_reg & ~sdaIn;
  assign stopCond  = scl & sclPrev_reg & ~sdaPrev_reg & sdaIn;
  assign lastIdx   = cmdLast(cmd_reg);
  assign loadIdx   = (state_reg == ssar_pkg::ST_ACK) ? 4'h0 :
                     (idx_reg == ssar_pkg::IDX_MAX) ? ssar_pkg::IDX_MAX : idx_reg + 4'h1;

  // R2 R3 R5 summary frame, count first, measurements low byte first
  assign sumBytes = '{ssar_pkg::SUMMARY_COUNT, status2, status1, alarm3, alarm2,
                      alarm1Flags, voltage[7:0], voltage[15:8], current[7:0],
                      current[15:8], tempSel_reg[7:0], tempSel_reg[15:8]};
  // R1 R8 alarm block read
  assign alarmBytes = '{ssar_pkg::ALARM_COUNT, alarm3, alarm2, alarm1Flags};

  always_comb
  begin
    loadByte = ssar_pkg::FILL_BYTE;
    if (lastIdx != 4'h0 && loadIdx < lastIdx)
    begin
      unique case (cmd_reg)
        ssar_pkg::CMD_SUMMARY: loadByte = sumBytes[loadIdx];
        // R7 word read, second status first
        ssar_pkg::CMD_UNIT:    loadByte = (loadIdx == 4'h0) ? status2 : status1;
        default:               loadByte = alarmBytes[loadIdx[1:0]];
      endcase
    end
    // R19 check byte follows the last data byte
    else if (lastIdx != 4'h0 && loadIdx == lastIdx)
      loadByte = crc_reg;
  end

  always_comb
  begin
    state_next     = state_reg;
    sclPrev_next   = scl;
    sdaPrev_next   = sdaIn;
    bitCnt_next    = bitCnt_reg;
    shift_next     = shift_reg;
    addrPhase_next = addrPhase_reg;
    rdMode_next    = rdMode_reg;
    cmd_next       = cmd_reg;
    idx_next       = idx_reg;
    crc_next       = crc_reg;
    txByte_next    = txByte_reg;
    sdaOe_next     = sdaOe_reg;
    invalidSet     = 1'b0;
    if (startCond)
    begin
      // Check byte covers the whole frame, so only a fresh start clears it
      state_next     = ssar_pkg::ST_RX;
      bitCnt_next    = 4'h0;
      addrPhase_next = 1'b1;
      sdaOe_next     = 1'b0;
      if (state_reg == ssar_pkg::ST_IDLE)
        crc_next = ssar_pkg::CRC_INIT;
    end
    else if (stopCond)
    begin
      state_next = ssar_pkg::ST_IDLE;
      sdaOe_next = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        ssar_pkg::ST_IDLE, ssar_pkg::ST_WAIT: ;
        ssar_pkg::ST_RX:
        begin
          if (sclRise && bitCnt_reg < ssar_pkg::BYTE_BITS)
          begin
            shift_next  = {shift_reg[6:0], sdaIn};
            bitCnt_next = bitCnt_reg + 4'h1;
          end
          else if (sclFall && bitCnt_reg == ssar_pkg::BYTE_BITS)
          begin
            if (addrPhase_reg && shift_reg[7:1] != ssar_pkg::DEV_ADDR)
              state_next = ssar_pkg::ST_IDLE;
            else
            begin
              state_next = ssar_pkg::ST_ACK;
              sdaOe_next = 1'b1;
              crc_next   = crcNext(crc_reg, shift_reg);
              if (addrPhase_reg)
                rdMode_next = shift_reg[0];
              else
              begin
                cmd_next   = shift_reg;
                invalidSet = (cmdLast(shift_reg) == 4'h0);
              end
            end
          end
        end
        ssar_pkg::ST_ACK:
        begin
          if (sclFall)
          begin
            sdaOe_next = 1'b0;
            // R1 read direction whenever the address read bit is set, after any start
            if (addrPhase_reg && rdMode_reg)
            begin
              state_next  = ssar_pkg::ST_TX;
              idx_next    = loadIdx;
              txByte_next = loadByte;
              sdaOe_next  = ~loadByte[7];
              bitCnt_next = 4'h0;
            end
            else if (addrPhase_reg)
            begin
              state_next     = ssar_pkg::ST_RX;
              addrPhase_next = 1'b0;
              bitCnt_next    = 4'h0;
            end
            else
              state_next = ssar_pkg::ST_WAIT;
          end
        end
        ssar_pkg::ST_TX:
        begin
          if (sclFall)
          begin
            if (bitCnt_reg[2:0] == ssar_pkg::TX_LAST_BIT)
            begin
              state_next  = ssar_pkg::ST_HACK;
              sdaOe_next  = 1'b0;
              bitCnt_next = 4'h0;
              crc_next    = crcNext(crc_reg, txByte_reg);
            end
            else
            begin
              bitCnt_next = bitCnt_reg + 4'h1;
              sdaOe_next  = ~txByte_reg[3'(ssar_pkg::TX_NEXT_TOP - bitCnt_reg[2:0])];
            end
          end
        end
        ssar_pkg::ST_HACK:
        begin
          // R4 host not-acknowledge closes the read
          if (sclRise && sdaIn)
            state_next = ssar_pkg::ST_WAIT;
          else if (sclFall)
          begin
            state_next  = ssar_pkg::ST_TX;
            idx_next    = loadIdx;
            txByte_next = loadByte;
            sdaOe_next  = ~loadByte[7];
          end
        end
        default: state_next = ssar_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg     <= ssar_pkg::ST_IDLE;
      sclPrev_reg   <= 1'b1;
      sdaPrev_reg   <= 1'b1;
      bitCnt_reg    <= 4'h0;
      shift_reg     <= 8'h00;
      addrPhase_reg <= 1'b0;
      rdMode_reg    <= 1'b0;
      cmd_reg       <= 8'h00;
      idx_reg       <= 4'h0;
      crc_reg       <= ssar_pkg::CRC_INIT;
      txByte_reg    <= 8'h00;
      sdaOe_reg     <= 1'b0;
      sdaOut_reg    <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      sclPrev_reg   <= sclPrev_next;
      sdaPrev_reg   <= sdaPrev_next;
      bitCnt_reg    <= bitCnt_next;
      shift_reg     <= shift_next;
      addrPhase_reg <= addrPhase_next;
      rdMode_reg    <= rdMode_next;
      cmd_reg       <= cmd_next;
      idx_reg       <= idx_next;
      crc_reg       <= crc_next;
      txByte_reg    <= txByte_next;
      sdaOe_reg     <= sdaOe_next;
      sdaOut_reg    <= 1'b0;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign sdaOut = sdaOut_reg;
  assign sdaOe  = sdaOe_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_start_restarts: assert property (startCond |=> state_reg == ssar_pkg::ST_RX && bitCnt_reg == 4'h0) // R1
    else $error("start did not restart address reception");
  chk_nack_ends: assert property (state_reg == ssar_pkg::ST_HACK && sclRise && sdaIn && !startCond && !stopCond
                                  |=> state_reg == ssar_pkg::ST_WAIT ##1 !sdaOe) // R4
    else $error("host nack did not end the read");
  chk_count_first: assert property (state_reg == ssar_pkg::ST_ACK && sclFall && addrPhase_reg && rdMode_reg
                                    && cmd_reg == ssar_pkg::CMD_SUMMARY && !startCond && !stopCond
                                    |=> txByte_reg == ssar_pkg::SUMMARY_COUNT && idx_reg == 4'h0) // R2
    else $error("summary read did not open with its byte count");
  chk_pec_last: assert property (state_reg == ssar_pkg::ST_TX && lastIdx != 4'h0 && idx_reg == lastIdx
                                 |-> txByte_reg == crc_reg) // R19
    else $error("last byte is not the check byte");
  chk_volt_lsb: assert property (state_reg == ssar_pkg::ST_TX && cmd_reg == ssar_pkg::CMD_SUMMARY
                                 && idx_reg == 4'h6 && $stable(voltage) |-> txByte_reg == voltage[7:0]) // R3
    else $error("voltage low byte not sent first");
  chk_unit_order: assert property (state_reg == ssar_pkg::ST_TX && cmd_reg == ssar_pkg::CMD_UNIT
                                   && $stable(status2) && idx_reg == 4'h0 |-> txByte_reg == status2) // R7
    else $error("unit read did not start with second status byte");
  chk_share_limit: assert property (shareCurrentMa > ssar_pkg::SHARE_LIMIT_MA |=> alarm2[0]) // R14
    else $error("share sourcing fault missing");
  chk_oring_setwins: assert property (oringEvt && clearFaults |=> oringFault_reg && alarm3[0]) // R15
    else $error("or-ing fault lost against clear");
  chk_destr_shut: assert property (oringEvt && oringDestructive |=> unitShutdown && status1[4]) // R16
    else $error("destructive or-ing fault did not shut down");
  chk_unused_zero: assert property (status2[4] == 1'b0 && status2[2] == 1'b0 && alarm3[2:1] == 2'b00) // R18
    else $error("unused status bit reads nonzero");

  cov_summary_pec: cover property (state_reg == ssar_pkg::ST_TX && cmd_reg == ssar_pkg::CMD_SUMMARY
                                   && idx_reg == ssar_pkg::SUMMARY_LAST);
  cov_alarm_read: cover property (state_reg == ssar_pkg::ST_TX && cmd_reg == ssar_pkg::CMD_ALARM);
  cov_host_nack: cover property (state_reg == ssar_pkg::ST_HACK ##1 state_reg == ssar_pkg::ST_WAIT);
  cov_shutdown: cover property (oringEvt && oringDestructive);

endmodule : ssar_readback

`default_nettype wire
